/* File: hw/pair_ident_and_deskew.sv */
// Purpose: Pair identification handshake and delay difference buffer
// Assumes: Frame strobes and data come from same-clock logic
// Notes: Pair activity levels come from pins and are synchronised
`timescale 1ns/10ps
`include "pair_ident_regs.svh"

// ****************************************
// Delay difference buffer
// ****************************************
module pair_fifo #(
    parameter int WIDTH = `PI_DATA_W,
    parameter int DEPTH = `PI_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] fill_reg;
    logic push;
    logic pop;

    assign in_ready = (fill_reg != DEPTH[AW:0]);
    assign out_valid = (fill_reg != '0);
    assign push = clk_en && in_valid && in_ready;
    assign pop = clk_en && out_valid && out_ready;
    assign out_data = mem[rd_ptr_reg];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                fill_reg <= fill_reg + 1'b1;
            end else if (pop && !push) begin
                fill_reg <= fill_reg - 1'b1;
            end
        end
    end
endmodule

// ****************************************
// Top
// ****************************************
module pair_ident_and_deskew
    import pair_ident_pkg::*;
#(
    parameter int SKEW_MAX_CYC = `PI_SKEW_MAX_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [1:0] unit_role,
    input wire logic three_pair_mode,
    input wire logic [1:0] assigned_num_0,
    input wire logic [1:0] assigned_num_1,
    input wire logic [1:0] assigned_num_2,
    input wire logic [2:0] pair_active_pin,
    input wire logic [2:0] rx_frame_strobe,
    input wire logic [2:0] rx_pair_tag_bit_first,
    input wire logic [2:0] rx_pair_tag_bit_second,
    input wire logic [2:0] rx_pair_tag_bit_third,
    output logic [2:0] tx_pair_tag_bit_first,
    output logic [2:0] tx_pair_tag_bit_second,
    output logic [2:0] tx_pair_tag_bit_third,
    input wire logic [2:0] rx_data_valid,
    output logic [2:0] rx_data_ready,
    input wire logic [7:0] rx_data_0,
    input wire logic [7:0] rx_data_1,
    input wire logic [7:0] rx_data_2,
    output logic core_valid,
    input wire logic core_ready,
    output logic [23:0] core_data,
    output logic [2:0] pair_done,
    output logic transparent,
    output logic skew_overflow
);
    logic [2:0] act_s1;
    logic [2:0] act_s2;
    logic [2:0] act_s3;
    logic [2:0] act_reg;
    logic [2:0] installed;
    logic [2:0] tag_mask;
    logic [2:0] rx_tag [3];
    logic [1:0] assigned [3];
    logic [7:0] rx_data [3];
    logic [7:0] fifo_data [3];
    logic [2:0] fifo_valid;
    logic [2:0] succ;
    ident_state_t state_reg [3];
    logic [2:0] cand_reg [3];
    logic [2:0] cnt_reg [3];
    logic [1:0] num_reg [3];
    logic [2:0] tx_tag_reg [3];
    logic all_done;
    logic drain;
    logic [`PI_SKEW_CNT_W-1:0] skew_cnt_reg;

    assign installed = three_pair_mode ? 3'h7 : 3'h3;
    assign tag_mask = three_pair_mode ? `PI_MASK_THREE : `PI_MASK_TWO;
    assign assigned[0] = assigned_num_0;
    assign assigned[1] = assigned_num_1;
    assign assigned[2] = assigned_num_2;
    assign rx_data[0] = rx_data_0;
    assign rx_data[1] = rx_data_1;
    assign rx_data[2] = rx_data_2;

    // ****************************************
    // Activity synchroniser
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            act_s1 <= 3'h0;
            act_s2 <= 3'h0;
            act_s3 <= 3'h0;
            act_reg <= 3'h0;
        end else if (clk_en) begin
            act_s1 <= pair_active_pin;
            act_s2 <= act_s1;
            act_s3 <= act_s2;
            act_reg <= (act_s2 & act_s3) | (act_reg & (act_s2 | act_s3));
        end
    end

    // ****************************************
    // Evaluation success and uniqueness
    // ****************************************
    always_comb begin
        logic claimed;
        claimed = 1'b0;
        succ = 3'h0;
        for (int i = 0; i < 3; i++) begin
            claimed = 1'b0;
            for (int j = 0; j < 3; j++) begin
                if (j != i && state_reg[j] == ID_DONE && cand_reg[j] == rx_tag[i]) begin
                    claimed = 1'b1;
                end
                if (j < i && succ[j] && cand_reg[j] == rx_tag[i]) begin
                    claimed = 1'b1;
                end
            end
            if (unit_role == ROLE_NET && state_reg[i] == ID_HUNT && rx_frame_strobe[i]
                && tag_valid(rx_tag[i], three_pair_mode) && rx_tag[i] == cand_reg[i]
                && cnt_reg[i] == `PI_CONSEC_FRAMES - 3'h1 && !claimed) begin
                succ[i] = 1'b1;
            end
        end
    end

    // ****************************************
    // Per-pair identification
    // ****************************************
    for (genvar g = 0; g < 3; g++) begin : g_pair
        assign rx_tag[g] = {rx_pair_tag_bit_third[g], rx_pair_tag_bit_second[g], rx_pair_tag_bit_first[g]} & tag_mask;
        assign tx_pair_tag_bit_first[g] = tx_tag_reg[g][0];
        assign tx_pair_tag_bit_second[g] = tx_tag_reg[g][1];
        assign tx_pair_tag_bit_third[g] = tx_tag_reg[g][2];
        assign pair_done[g] = (state_reg[g] == ID_DONE);

        // One state, counter and pattern per pair
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                state_reg[g] <= ID_IDLE;
                cand_reg[g] <= `PI_TAG_NONE;
                cnt_reg[g] <= 3'h0;
                num_reg[g] <= 2'h0;
            end else if (clk_en) begin
                if (!act_reg[g] || !installed[g] || unit_role == ROLE_REGEN) begin
                    state_reg[g] <= ID_IDLE;
                    cnt_reg[g] <= 3'h0;
                    cand_reg[g] <= `PI_TAG_NONE;
                end else begin
                    case (state_reg[g])
                        ID_IDLE: begin
                            state_reg[g] <= ID_HUNT;
                            cnt_reg[g] <= 3'h0;
                            if (unit_role == ROLE_LINE) begin
                                num_reg[g] <= assigned[g];
                                cand_reg[g] <= tag_of_num(assigned[g]);
                            end
                        end
                        ID_HUNT: begin
                            if (rx_frame_strobe[g]) begin
                                if (unit_role == ROLE_LINE) begin
                                    if (rx_tag[g] == cand_reg[g]) begin
                                        if (cnt_reg[g] == `PI_CONSEC_FRAMES - 3'h1) begin
                                            state_reg[g] <= ID_DONE;
                                        end
                                        cnt_reg[g] <= cnt_reg[g] + 3'h1;
                                    end else begin
                                        cnt_reg[g] <= 3'h0;
                                    end
                                end else if (!tag_valid(rx_tag[g], three_pair_mode)) begin
                                    cnt_reg[g] <= 3'h0;
                                end else if (rx_tag[g] != cand_reg[g] || cnt_reg[g] == 3'h0) begin
                                    cand_reg[g] <= rx_tag[g];
                                    cnt_reg[g] <= 3'h1;
                                end else if (succ[g]) begin
                                    state_reg[g] <= ID_DONE;
                                    num_reg[g] <= num_of_tag(rx_tag[g]);
                                    cnt_reg[g] <= `PI_CONSEC_FRAMES;
                                end else if (cnt_reg[g] != `PI_CONSEC_FRAMES - 3'h1) begin
                                    cnt_reg[g] <= cnt_reg[g] + 3'h1;
                                end
                            end
                        end
                        ID_DONE: begin
                            state_reg[g] <= ID_DONE;
                        end
                        default: begin
                            state_reg[g] <= ID_IDLE;
                        end
                    endcase
                end
            end
        end

        // Outgoing tag bits
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                tx_tag_reg[g] <= `PI_TAG_NONE;
            end else if (clk_en) begin
                if (unit_role == ROLE_REGEN) begin
                    tx_tag_reg[g] <= rx_tag[g];
                end else if (unit_role == ROLE_LINE) begin
                    tx_tag_reg[g] <= (state_reg[g] != ID_IDLE) ? cand_reg[g] : `PI_TAG_NONE;
                end else if (state_reg[g] == ID_DONE) begin
                    tx_tag_reg[g] <= cand_reg[g];
                end else begin
                    tx_tag_reg[g] <= `PI_TAG_ONES & tag_mask;
                end
            end
        end

        pair_fifo #(
            .WIDTH(`PI_DATA_W),
            .DEPTH(`PI_FIFO_DEPTH)
        ) u_fifo (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .clk_en(clk_en),
            .in_valid(rx_data_valid[g]),
            .in_ready(rx_data_ready[g]),
            .in_data(rx_data[g]),
            .out_valid(fifo_valid[g]),
            .out_ready(drain || !transparent),
            .out_data(fifo_data[g])
        );

        a_no_exam_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
            !act_reg[g] && clk_en |=> state_reg[g] == ID_IDLE && cnt_reg[g] == 3'h0)
            else $error("pair examined while inactive");
        a_net_ones_hunt: assert property (@(posedge clk_sys) disable iff (!rst_n)
            unit_role == ROLE_NET && state_reg[g] != ID_DONE && clk_en |=> tx_tag_reg[g] == tag_mask)
            else $error("network tags not all ones before identification");
        a_net_hold_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
            unit_role == ROLE_NET && pair_done[g] && $past(pair_done[g]) && $past(pair_done[g], 2)
            |-> $stable(tx_tag_reg[g]))
            else $error("reflected tag changed during activation");
        a_line_tx_own: assert property (@(posedge clk_sys) disable iff (!rst_n)
            unit_role == ROLE_LINE && state_reg[g] == ID_HUNT && clk_en
            |=> tx_tag_reg[g] == tag_of_num(num_reg[g]))
            else $error("line side tag not one-hot of its number");
        a_done_after_six: assert property (@(posedge clk_sys) disable iff (!rst_n)
            $rose(pair_done[g]) && unit_role != ROLE_REGEN
            |-> $past(cnt_reg[g]) == `PI_CONSEC_FRAMES - 3'h1 && $past(rx_frame_strobe[g])
            && $past(rx_tag[g]) == cand_reg[g])
            else $error("pair done without six matching frames");
        a_count_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
            unit_role == ROLE_NET && state_reg[g] == ID_HUNT && act_reg[g] && installed[g] && clk_en
            && rx_frame_strobe[g] && !tag_valid(rx_tag[g], three_pair_mode) |=> cnt_reg[g] == 3'h0)
            else $error("counter kept on invalid pattern");
        a_regen_forward: assert property (@(posedge clk_sys) disable iff (!rst_n)
            unit_role == ROLE_REGEN && clk_en |=> tx_tag_reg[g] == $past(rx_tag[g]))
            else $error("regenerator altered tag bits");
        a_net_learn_num: assert property (@(posedge clk_sys) disable iff (!rst_n)
            unit_role == ROLE_NET && $rose(pair_done[g]) |-> tag_of_num(num_reg[g]) == cand_reg[g])
            else $error("learned number does not match pattern");
    end

    a_unique_patterns: assert property (@(posedge clk_sys) disable iff (!rst_n)
        unit_role == ROLE_NET && pair_done[0] && pair_done[1] |-> cand_reg[0] != cand_reg[1])
        else $error("same pattern accepted on two pairs");

    // ****************************************
    // Transparency and core frame mapping
    // ****************************************
    assign all_done = ((pair_done & installed) == installed) && unit_role != ROLE_REGEN;
    assign drain = transparent && ((fifo_valid & installed) == installed) && (!core_valid || core_ready);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            transparent <= 1'b0;
        end else if (clk_en) begin
            transparent <= all_done;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            core_valid <= 1'b0;
            core_data <= 24'h0;
        end else if (clk_en) begin
            if (drain) begin
                core_valid <= 1'b1;
                for (int i = 0; i < 3; i++) begin
                    for (int k = 0; k < 3; k++) begin
                        if (installed[i] && num_reg[i] == 2'(k + 1)) begin
                            core_data[k*8 +: 8] <= fifo_data[i];
                        end
                    end
                end
            end else if (core_ready) begin
                core_valid <= 1'b0;
            end
        end
    end

    a_transp_all_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
        transparent |-> $past((pair_done & installed) == installed))
        else $error("transparent before all pairs identified");
    a_transp_min_frames: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(transparent) |-> $past(cnt_reg[0]) == `PI_CONSEC_FRAMES)
        else $error("transparent before enough frames");

    // ****************************************
    // Delay difference supervision
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            skew_cnt_reg <= '0;
            skew_overflow <= 1'b0;
        end else if (clk_en) begin
            if (!transparent) begin
                skew_cnt_reg <= '0;
                skew_overflow <= 1'b0;
            end else if ((fifo_valid & installed) != 3'h0 && (fifo_valid & installed) != installed) begin
                if (skew_cnt_reg >= SKEW_MAX_CYC[`PI_SKEW_CNT_W-1:0]) begin
                    skew_overflow <= 1'b1;
                end else begin
                    skew_cnt_reg <= skew_cnt_reg + 1'b1;
                end
            end else begin
                skew_cnt_reg <= '0;
            end
        end
    end

    c_net_ident: cover property (@(posedge clk_sys) unit_role == ROLE_NET && $rose(transparent));
    c_line_ident: cover property (@(posedge clk_sys) unit_role == ROLE_LINE && $rose(transparent));
    c_core_word: cover property (@(posedge clk_sys) core_valid && core_ready);
    c_skew_over: cover property (@(posedge clk_sys) $rose(skew_overflow));
endmodule

/* File: hw/pair_ident_regs.svh */
// Purpose: Constants for pair identification and deskew
// Assumes: 200 MHz system clock
// Notes: Counts derived from times in their own units
`ifndef PAIR_IDENT_REGS_SVH
`define PAIR_IDENT_REGS_SVH

// ****************************************
// Sizes
// ****************************************
`define PI_NUM_PAIRS 3
`define PI_TAG_W 3
`define PI_DATA_W 8
`define PI_FIFO_DEPTH 16
`define PI_CNT_W 3

// ****************************************
// Timing
// ****************************************
`define PI_CONSEC_FRAMES 3'h6
`define PI_MIN_FRAMES 12
`define PI_MIN_DELAY_MS 72
`define PI_CLK_MHZ 200
`define PI_SKEW_MAX_US 60
`define PI_SKEW_MAX_CYC (`PI_SKEW_MAX_US * `PI_CLK_MHZ)
`define PI_SKEW_CNT_W 14

// ****************************************
// Tag patterns
// ****************************************
`define PI_TAG_NONE 3'h0
`define PI_TAG_P1 3'h1
`define PI_TAG_P2 3'h2
`define PI_TAG_P3 3'h4
`define PI_TAG_ONES 3'h7
`define PI_MASK_TWO 3'h3
`define PI_MASK_THREE 3'h7

`endif

/* File: hw/pair_ident_pkg.sv */
// Purpose: Types and decode functions for pair identification
// Assumes: Constants header present
// Notes: None
`include "pair_ident_regs.svh"
package pair_ident_pkg;
    typedef enum logic [1:0] {
        ID_IDLE = 2'b00,
        ID_HUNT = 2'b01,
        ID_DONE = 2'b10
    } ident_state_t;

    typedef enum logic [1:0] {
        ROLE_LINE = 2'b00,
        ROLE_NET = 2'b01,
        ROLE_REGEN = 2'b10
    } unit_role_t;

    function automatic logic [2:0] tag_of_num(input logic [1:0] num);
        case (num)
            2'h1: tag_of_num = `PI_TAG_P1;
            2'h2: tag_of_num = `PI_TAG_P2;
            2'h3: tag_of_num = `PI_TAG_P3;
            default: tag_of_num = `PI_TAG_NONE;
        endcase
    endfunction

    function automatic logic [1:0] num_of_tag(input logic [2:0] tag);
        case (tag)
            `PI_TAG_P1: num_of_tag = 2'h1;
            `PI_TAG_P2: num_of_tag = 2'h2;
            `PI_TAG_P3: num_of_tag = 2'h3;
            default: num_of_tag = 2'h0;
        endcase
    endfunction

    function automatic logic tag_valid(input logic [2:0] tag, input logic three);
        tag_valid = (tag == `PI_TAG_P1) || (tag == `PI_TAG_P2) || (three && (tag == `PI_TAG_P3));
    endfunction
endpackage

/* File: test/peer_unit_model.sv */
// Purpose: Peer unit common circuitry across the line pairs
// Assumes: One frame per pair every GAP cycles, pairs staggered by one cycle
// Notes: Tag lines toggle between frames so stale sampling shows up
`timescale 1ns/10ps

// ****************************************
// Peer model
// ****************************************
module peer_unit_model #(
    parameter int GAP = 4
) (
    input wire logic clk_sys,
    input wire logic run,
    input wire logic reflect,
    input wire logic [8:0] send_tag,
    input wire logic [2:0] tx_first,
    input wire logic [2:0] tx_second,
    input wire logic [2:0] tx_third,
    output logic [2:0] strobe,
    output logic [2:0] tag_first,
    output logic [2:0] tag_second,
    output logic [2:0] tag_third
);
    logic [3:0] cnt = 4'h0;
    logic [2:0] tg [3] = '{default: 3'h0};
    logic [2:0] seen [3] = '{default: 3'h0};
    logic [2:0] hits [3] = '{default: 3'h0};
    logic [2:0] got;

    assign tag_first = {tg[2][0], tg[1][0], tg[0][0]};
    assign tag_second = {tg[2][1], tg[1][1], tg[0][1]};
    assign tag_third = {tg[2][2], tg[1][2], tg[0][2]};
    initial strobe = 3'h0;

    always @(negedge clk_sys) begin
        cnt <= (!run || cnt == 4'(GAP - 1)) ? 4'h0 : cnt + 4'h1;
        for (int i = 0; i < 3; i++) begin
            got = {tx_third[i], tx_second[i], tx_first[i]};
            strobe[i] <= run && (cnt == 4'(i));
            if (run && (cnt == 4'(i))) begin
                if (!reflect) begin
                    tg[i] <= send_tag[3*i+:3];
                end else begin
                    tg[i] <= (hits[i] == 3'h6) ? seen[i] : 3'h7;
                    if (hits[i] != 3'h6) begin
                        seen[i] <= got;
                        hits[i] <= !$onehot(got) ? 3'h0 : (got != seen[i]) ? 3'h1 : hits[i] + 3'h1;
                    end
                end
            end else begin
                tg[i] <= ~tg[i];
            end
            if (!run) begin
                hits[i] <= 3'h0;
            end
        end
    end
endmodule

/* File: test/pair_ident_and_deskew_bench.sv */
// Purpose: Self-checking bench for pair identification and deskew
// Assumes: Peer model supplies frames and tag bits
// Notes: Skew limit shortened to 20 cycles
`timescale 1ns/10ps
`include "pair_ident_regs.svh"

// ****************************************
// Bench
// ****************************************
module pair_ident_and_deskew_bench
    import pair_ident_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] unit_role, num_0, num_1, num_2;
    logic [2:0] act, strobe, rx_f, rx_s, rx_t, tx_f, tx_s, tx_t, rx_dv, rx_rdy, done;
    logic [7:0] d0, d1, d2;
    logic [23:0] core_data;
    logic core_valid, core_ready, transparent, skew_overflow, run, reflect;
    logic [8:0] send_tag;
    logic clk_en = 1'b1;
    logic three_pair = 1'b1;
    int error_cnt = 0;
    int checked = 0;

    pair_ident_and_deskew #(.SKEW_MAX_CYC(20)) u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .unit_role(unit_role), .three_pair_mode(three_pair),
        .assigned_num_0(num_0), .assigned_num_1(num_1), .assigned_num_2(num_2), .pair_active_pin(act),
        .rx_frame_strobe(strobe), .rx_pair_tag_bit_first(rx_f), .rx_pair_tag_bit_second(rx_s),
        .rx_pair_tag_bit_third(rx_t), .tx_pair_tag_bit_first(tx_f), .tx_pair_tag_bit_second(tx_s),
        .tx_pair_tag_bit_third(tx_t), .rx_data_valid(rx_dv), .rx_data_ready(rx_rdy), .rx_data_0(d0),
        .rx_data_1(d1), .rx_data_2(d2), .core_valid(core_valid), .core_ready(core_ready),
        .core_data(core_data), .pair_done(done), .transparent(transparent), .skew_overflow(skew_overflow));

    peer_unit_model u_peer (
        .clk_sys(clk_sys), .run(run), .reflect(reflect), .send_tag(send_tag), .tx_first(tx_f),
        .tx_second(tx_s), .tx_third(tx_t), .strobe(strobe), .tag_first(rx_f), .tag_second(rx_s),
        .tag_third(rx_t));

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    function automatic logic [2:0] txp(input int i);
        return {tx_t[i], tx_s[i], tx_f[i]};
    endfunction

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic frames(input int i, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            while (strobe[i] !== 1'b1) @(posedge clk_sys);
        end
        @(negedge clk_sys);
    endtask

    task automatic start(input logic [8:0] tags, input logic refl);
        send_tag <= tags;
        reflect <= refl;
        act <= 3'h7;
        repeat (8) @(negedge clk_sys);
        run <= 1'b1;
    endtask

    task automatic stop();
        run <= 1'b0;
        act <= 3'h0;
        repeat (8) @(negedge clk_sys);
        check({skew_overflow, transparent, done}, 5'h0);
    endtask

    task automatic wait_core();
        int k = 0;
        while (core_valid !== 1'b1 && k < 50) begin
            @(negedge clk_sys);
            k++;
        end
        check(core_valid, 1'b1);
    endtask

    task automatic net_ident();
        unit_role <= ROLE_NET;
        start({`PI_TAG_P3, `PI_TAG_P1, `PI_TAG_P2}, 1'b0);
        frames(0, 5);
        check(done, 3'h0);
        check(txp(0), `PI_TAG_ONES);
        frames(0, 1);
        check(done, 3'h1);
        check(txp(0), `PI_TAG_ONES);
        frames(2, 1);
        check({transparent, done}, 4'h7);
        check({txp(1), txp(0)}, {`PI_TAG_P1, `PI_TAG_P2});
        @(negedge clk_sys);
        check(transparent, 1'b1);
        check({txp(2), txp(1), txp(0)}, {`PI_TAG_P3, `PI_TAG_P1, `PI_TAG_P2});
        rx_dv <= 3'h7;
        {d2, d1, d0} <= 24'h332211;
        core_ready <= 1'b1;
        @(negedge clk_sys);
        rx_dv <= 3'h0;
        wait_core();
        check(core_data, 24'h331122);
        check(skew_overflow, 1'b0);
    endtask

    task automatic fifo_fill();
        int n = 0;
        @(negedge clk_sys);
        core_ready <= 1'b0;
        repeat (24) begin
            rx_dv <= (rx_rdy === 3'h7) ? 3'h7 : 3'h0;
            {d2, d1, d0} <= {3{8'(n)}};
            n = (rx_rdy === 3'h7) ? n + 1 : n;
            @(negedge clk_sys);
        end
        rx_dv <= 3'h0;
        check(rx_rdy, 3'h0);
        check(n >= 16, 1'b1);
        core_ready <= 1'b1;
        for (int k = 0; k < n; k++) begin
            wait_core();
            check(core_data, {3{8'(k)}});
            @(negedge clk_sys);
        end
    endtask

    task automatic skew_check();
        rx_dv <= 3'h1;
        @(negedge clk_sys);
        rx_dv <= 3'h0;
        repeat (30) @(negedge clk_sys);
        check(skew_overflow, 1'b1);
    endtask

    task automatic net_two();
        unit_role <= ROLE_NET;
        three_pair <= 1'b0;
        start({`PI_TAG_P3, `PI_TAG_P1, `PI_TAG_P2}, 1'b0);
        frames(0, 5);
        clk_en <= 1'b0;
        repeat (20) @(negedge clk_sys);
        check(done, 3'h0);
        check(txp(0), `PI_TAG_ONES & `PI_MASK_TWO);
        clk_en <= 1'b1;
        frames(1, 2);
        check({transparent, done}, 4'h3);
        @(negedge clk_sys);
        check({transparent, done}, 4'hb);
        check({txp(1), txp(0)}, {`PI_TAG_P1, `PI_TAG_P2});
        stop();
        three_pair <= 1'b1;
    endtask

    task automatic net_dup();
        start({`PI_TAG_P3, `PI_TAG_P1, `PI_TAG_P1}, 1'b0);
        frames(2, 3);
        send_tag[8:6] <= 3'h3;
        frames(2, 1);
        send_tag[8:6] <= `PI_TAG_P3;
        frames(2, 5);
        check(done, 3'h1);
        frames(2, 1);
        check(done, 3'h5);
        check(transparent, 1'b0);
        stop();
    endtask

    task automatic line_ident();
        unit_role <= ROLE_LINE;
        num_0 <= 2'h3;
        num_1 <= 2'h1;
        num_2 <= 2'h2;
        start(9'h0, 1'b1);
        check({txp(2), txp(1), txp(0)}, {`PI_TAG_P2, `PI_TAG_P1, `PI_TAG_P3});
        frames(2, 11);
        check(done, 3'h0);
        frames(2, 1);
        @(negedge clk_sys);
        check(done, 3'h7);
        @(negedge clk_sys);
        check(transparent, 1'b1);
        stop();
    endtask

    task automatic regen();
        logic [8:0] prev;
        unit_role <= ROLE_REGEN;
        start({`PI_TAG_P3, `PI_TAG_P2, `PI_TAG_P1}, 1'b0);
        repeat (12) begin
            @(posedge clk_sys);
            prev = {rx_t, rx_s, rx_f};
            @(negedge clk_sys);
            check({tx_t, tx_s, tx_f}, prev);
        end
        check(transparent, 1'b0);
        stop();
    endtask

    initial begin
        unit_role = ROLE_NET;
        {num_0, num_1, num_2} = 6'h0;
        {act, rx_dv, d0, d1, d2} = 30'h0;
        {core_ready, run, reflect, send_tag} = 12'h0;
        repeat (4) @(negedge clk_sys);
        check({tx_t, tx_s, tx_f, rx_rdy, transparent}, 13'he);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        net_ident();
        fifo_fill();
        skew_check();
        stop();
        net_dup();
        line_ident();
        regen();
        net_two();
        end_sim();
    end

    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
endmodule
